// ==== hdl/bwdt_pkg.sv ====
`default_nettype none

package bwdt_pkg;

    // Host I/O port addresses
    localparam logic [11:0] ADDR_ARM    = 12'h443;
    localparam logic [11:0] ADDR_DISARM = 12'h843;
    localparam logic [11:0] ADDR_KICK   = 12'h043;
    localparam int          ADDR_W      = 12;

    // Action selector bit positions (set = link closed)
    localparam int ACT_NMI_BIT = 0;
    localparam int ACT_RST_BIT = 1;

    // Period selector codes, bit n = link pair n closed
    localparam logic [3:0] PER_1S   = 4'h4;
    localparam logic [3:0] PER_2S   = 4'hC;
    localparam logic [3:0] PER_10S  = 4'h2;
    localparam logic [3:0] PER_20S  = 4'hA;
    localparam logic [3:0] PER_110S = 4'h1;
    localparam logic [3:0] PER_220S = 4'h9;

    localparam int SEC_W = 8;

    // Timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int CLK_FREQ_HZ    = 200_000_000;
    localparam int SECOND_S       = 1;
    localparam int CYCLES_PER_SEC = CLK_FREQ_HZ * SECOND_S;
    localparam int PRESC_W        = 28;
    localparam int PULSE_TIME_NS  = 1000;
    localparam int PULSE_CYCLES   =
        (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W        = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ARMED = 3'h2,
        ST_FIRE  = 3'h4
    } bwdt_state_type;

    // Seconds for a selector code; unknown codes take the longest
    function automatic logic [SEC_W-1:0] bwdt_period_secs(
        input logic [3:0] code);
        case (code)
            PER_1S:   bwdt_period_secs = 8'h01;
            PER_2S:   bwdt_period_secs = 8'h02;
            PER_10S:  bwdt_period_secs = 8'h0A;
            PER_20S:  bwdt_period_secs = 8'h14;
            PER_110S: bwdt_period_secs = 8'h6E;
            default:  bwdt_period_secs = 8'hDC;
        endcase
    endfunction : bwdt_period_secs

endpackage : bwdt_pkg

`default_nettype wire

// ==== hdl/bwdt_prescaler.sv ====
`default_nettype none

module bwdt_prescaler
    import bwdt_pkg::*;
#(
    parameter int CYCLES_PER_SEC_P = CYCLES_PER_SEC
) (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic clear_i,
    output var  logic sec_tick_o
);

    localparam logic [PRESC_W-1:0] LAST =
        PRESC_W'(CYCLES_PER_SEC_P - 1);

    logic [PRESC_W-1:0] cnt_reg;

    // Clear restarts a full second, so a retrigger never sees a short one
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (clear_i || cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + PRESC_W'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sec_tick_o <= 1'b0;
        end else begin
            sec_tick_o <= !clear_i && cnt_reg == LAST;
        end
    end

endmodule : bwdt_prescaler

`default_nettype wire

// ==== hdl/bwdt_top.sv ====
// Overview of operation
// R01 - Read at 443h arms the watchdog
// R02 - Read at 843h disarms, cancelling time-out
// R03 - Software retriggers before interval ends
// R04 - Expiry fires reset or NMI per setting
// R05 - Interval selectable: 1,2,10,20,110,220 seconds
// R06 - Action: reset, NMI, or watchdog disabled
// R07 - Ports 043h and 443h both control watchdog
// R08 - Arming while armed restarts count
`default_nettype none

module bwdt_top
    import bwdt_pkg::*;
#(
    parameter int CYCLES_PER_SEC_P = CYCLES_PER_SEC
) (
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              io_rd_n_i,
    input  wire logic [ADDR_W-1:0] io_addr_i,
    input  wire logic [1:0]        timeout_action_select_i,
    input  wire logic [3:0]        timeout_period_select_i,
    output var  logic              sys_reset_o,
    output var  logic              nmi_o,
    output var  logic              armed_o
);

    // Pin synchronisers
    logic              rd_n_s1_reg;
    logic              rd_n_s2_reg;
    logic              rd_n_prev_reg;
    logic [ADDR_W-1:0] addr_s1_reg;
    logic [ADDR_W-1:0] addr_s2_reg;
    logic [1:0]        act_s1_reg;
    logic [1:0]        act_s2_reg;
    logic [3:0]        per_s1_reg;
    logic [3:0]        per_s2_reg;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_n_s1_reg   <= 1'b1;
            rd_n_s2_reg   <= 1'b1;
            rd_n_prev_reg <= 1'b1;
            addr_s1_reg   <= '0;
            addr_s2_reg   <= '0;
            act_s1_reg    <= '0;
            act_s2_reg    <= '0;
            per_s1_reg    <= '0;
            per_s2_reg    <= '0;
        end else begin
            rd_n_s1_reg   <= io_rd_n_i;
            rd_n_s2_reg   <= rd_n_s1_reg;
            rd_n_prev_reg <= rd_n_s2_reg;
            addr_s1_reg   <= io_addr_i;
            addr_s2_reg   <= addr_s1_reg;
            act_s1_reg    <= timeout_action_select_i;
            act_s2_reg    <= act_s1_reg;
            per_s1_reg    <= timeout_period_select_i;
            per_s2_reg    <= per_s1_reg;
        end
    end

    // Address passes the same two stages as the strobe, so it lines up with the edge seen here
    logic rd_evt;
    logic arm_evt;
    logic disarm_evt;
    logic kick_evt;
    logic act_en;
    logic act_rst;
    logic [SEC_W-1:0] period_secs;

    assign rd_evt      = rd_n_prev_reg && !rd_n_s2_reg;
    assign arm_evt     = rd_evt && addr_s2_reg == ADDR_ARM;         // R01 R07
    assign disarm_evt  = rd_evt && addr_s2_reg == ADDR_DISARM;      // R02
    assign kick_evt    = rd_evt && addr_s2_reg == ADDR_KICK;        // R07
    assign act_rst     = act_s2_reg[ACT_RST_BIT];                   // R06
    assign act_en      = act_rst || act_s2_reg[ACT_NMI_BIT];        // R06
    assign period_secs = bwdt_period_secs(per_s2_reg);              // R05

    bwdt_state_type    state_reg;
    logic [SEC_W-1:0]  sec_cnt_reg;
    logic [PULSE_W-1:0] pulse_cnt_reg;
    logic              sec_tick;
    logic              restart;
    logic              expire;

    assign restart = (arm_evt || kick_evt) && state_reg == ST_ARMED; // R08
    assign expire  = state_reg == ST_ARMED && sec_tick && !restart
                     && !disarm_evt && act_en
                     && sec_cnt_reg + SEC_W'(1) >= period_secs;     // R04

    bwdt_prescaler #(
        .CYCLES_PER_SEC_P (CYCLES_PER_SEC_P)
    ) u_presc (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .clear_i    (state_reg != ST_ARMED || restart),
        .sec_tick_o (sec_tick)
    );

    // Disarm and a disabled action both win over everything
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (arm_evt && act_en) begin
                        state_reg <= ST_ARMED;                       // R01
                    end
                end
                ST_ARMED: begin
                    if (disarm_evt || !act_en) begin
                        state_reg <= ST_IDLE;                        // R02 R06
                    end else if (expire) begin
                        state_reg <= ST_FIRE;                        // R04
                    end
                end
                ST_FIRE: begin
                    if (disarm_evt || !act_en ||
                        pulse_cnt_reg == PULSE_W'(PULSE_CYCLES - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sec_cnt_reg <= '0;
        end else if (state_reg != ST_ARMED || restart) begin
            sec_cnt_reg <= '0;                                       // R08
        end else if (sec_tick) begin
            sec_cnt_reg <= sec_cnt_reg + SEC_W'(1);                  // R05
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pulse_cnt_reg <= '0;
        end else if (state_reg == ST_FIRE) begin
            pulse_cnt_reg <= pulse_cnt_reg + PULSE_W'(1);
        end else begin
            pulse_cnt_reg <= '0;
        end
    end

    // Outputs follow the next state so they come straight off flops
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_reset_o <= 1'b0;
            nmi_o       <= 1'b0;
            armed_o     <= 1'b0;
        end else begin
            if (expire) begin
                sys_reset_o <= act_rst;                              // R04
                nmi_o       <= !act_rst;                             // R04
            end else if (state_reg != ST_FIRE || disarm_evt || !act_en
                         || pulse_cnt_reg == PULSE_W'(PULSE_CYCLES - 1))
            begin
                sys_reset_o <= 1'b0;
                nmi_o       <= 1'b0;
            end
            armed_o <= (state_reg == ST_IDLE && arm_evt && act_en) ||
                       (state_reg == ST_ARMED && !disarm_evt && act_en
                        && !expire);
        end
    end

    property p_arm;
        @(posedge mclk_i) disable iff (sys_rst_i)
        state_reg == ST_IDLE && arm_evt && act_en
        |=> state_reg == ST_ARMED && armed_o && sec_cnt_reg == 8'h00;
    endproperty
    a_arm: assert property (p_arm) // R01
        else $error("arm read did not arm");

    property p_disarm;
        @(posedge mclk_i) disable iff (sys_rst_i)
        disarm_evt |=> state_reg == ST_IDLE && !sys_reset_o && !nmi_o;
    endproperty
    a_disarm: assert property (p_disarm) // R02
        else $error("disarm read did not disarm");

    property p_fire;
        @(posedge mclk_i) disable iff (sys_rst_i)
        expire |=> sys_reset_o == $past(act_rst) && sys_reset_o != nmi_o
                   ##1 (sys_reset_o || nmi_o);
    endproperty
    a_fire: assert property (p_fire) // R04
        else $error("expiry gave wrong action");

    property p_period;
        @(posedge mclk_i) disable iff (sys_rst_i)
        state_reg == ST_ARMED |-> sec_cnt_reg < period_secs;
    endproperty
    a_period: assert property (p_period) // R05
        else $error("seconds count passed selected period");

    property p_disabled;
        @(posedge mclk_i) disable iff (sys_rst_i)
        !act_en |=> state_reg == ST_IDLE && !armed_o
                    ##1 !sys_reset_o && !nmi_o;
    endproperty
    a_disabled: assert property (p_disabled) // R06
        else $error("disabled watchdog still active");

    property p_kick;
        @(posedge mclk_i) disable iff (sys_rst_i)
        state_reg == ST_ARMED && kick_evt && !disarm_evt && act_en
        |=> state_reg == ST_ARMED && sec_cnt_reg == 8'h00 && !sec_tick;
    endproperty
    a_kick: assert property (p_kick) // R07
        else $error("kick read did not restart count");

    property p_rearm;
        @(posedge mclk_i) disable iff (sys_rst_i)
        state_reg == ST_ARMED && arm_evt && act_en
        |=> sec_cnt_reg == 8'h00 && !$rose(sys_reset_o) && !$rose(nmi_o);
    endproperty
    a_rearm: assert property (p_rearm) // R08
        else $error("re-arm did not restart count");

endmodule : bwdt_top

`default_nettype wire

// ==== bench/bwdt_host_model.sv ====
`default_nettype none

module bwdt_host_model
    import bwdt_pkg::*;
(
    input  wire logic              mclk_i,
    output var  logic              io_rd_n_o,
    output var  logic [ADDR_W-1:0] io_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        io_rd_n_o = 1'b1;
        io_addr_o = 12'h000;
    end

    // Slow callers pass a longer low time; at least 3 clocks each way
    task automatic io_read(input logic [ADDR_W-1:0] addr, input int low_cyc);
        @(posedge mclk_i);
        io_addr_o <= addr;
        io_rd_n_o <= 1'b0;
        repeat (low_cyc) @(posedge mclk_i);
        io_rd_n_o <= 1'b1;
        // Released bus: no stale address left for the decoder
        io_addr_o <= ~addr;
        repeat (3) @(posedge mclk_i);
    endtask : io_read

endmodule : bwdt_host_model

`default_nettype wire

// ==== bench/test_bwdt_top.sv ====
`default_nettype none

module test_bwdt_top
    import bwdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short second keeps the 220 s case near 4400 clocks
    localparam int CPS = 20;

    logic              mclk;
    logic              rst;
    logic              rd_n;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        act;
    logic [3:0]        per;
    logic              rst_req;
    logic              nmi;
    logic              armed;
    int                n_mismatch;
    int                cmp_count;
    int                cyc = 0;
    logic [3:0]        codes [6] = '{PER_1S, PER_2S, PER_10S,
                                     PER_20S, PER_110S, PER_220S};
    int                secs  [6] = '{1, 2, 10, 20, 110, 220};
    logic [1:0]        acts  [6] = '{2'b10, 2'b01, 2'b11,
                                     2'b01, 2'b10, 2'b01};

    bwdt_top #(
        .CYCLES_PER_SEC_P(CPS)
    ) u_bwdt_top (
        .mclk_i                  (mclk),
        .sys_rst_i               (rst),
        .io_rd_n_i               (rd_n),
        .io_addr_i               (addr),
        .timeout_action_select_i (act),
        .timeout_period_select_i (per),
        .sys_reset_o             (rst_req),
        .nmi_o                   (nmi),
        .armed_o                 (armed)
    );

    bwdt_host_model u_bwdt_host_model (
        .mclk_i    (mclk),
        .io_rd_n_o (rd_n),
        .io_addr_o (addr)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    // Links are synchronised, so give them a few clocks to settle
    task automatic setup(input logic [1:0] a, input logic [3:0] c);
        @(posedge mclk);
        act <= a;
        per <= c;
        repeat (4) @(posedge mclk);
    endtask : setup

    task automatic quiet(input int k);
        logic bad;
        bad = 1'b0;
        repeat (k) begin
            tick();
            bad = bad | (rst_req !== 1'b0) | (nmi !== 1'b0);
        end
        check("no_fire", 1'b0, bad);
    endtask : quiet

    // Called right after the last arming read returns
    task automatic fire_check(input int s, input logic [1:0] a);
        int n;
        int w;
        n = 0;
        w = 0;
        #1;
        while (rst_req !== 1'b1 && nmi !== 1'b1 && n < s * CPS + 20) begin
            tick();
            n++;
        end
        check("fire_time", 1'b1, n >= s * CPS - 4 && n <= s * CPS + 1);
        check("reset_out", a[1], rst_req);
        check("nmi_out", a == 2'b01, nmi);
        check("armed_out", 1'b0, armed);
        while ((rst_req === 1'b1 || nmi === 1'b1) && w < 300) begin
            tick();
            w++;
        end
        check("pulse_len", 1'b1, w >= 199 && w <= 201);
    endtask : fire_check

    task automatic t_periods();
        for (int i = 0; i < 6; i++) begin
            setup(acts[i], codes[i]);
            u_bwdt_host_model.io_read(ADDR_ARM, 4);
            check("armed_out", 1'b1, armed);
            fire_check(secs[i], acts[i]);
        end
    endtask : t_periods

    task automatic t_kick();
        setup(2'b10, PER_1S);
        u_bwdt_host_model.io_read(ADDR_ARM, 4);
        for (int i = 0; i < 6; i++) begin
            repeat (4) @(posedge mclk);
            // Ends on a 4-clock arm so the fire window stays aligned
            u_bwdt_host_model.io_read(i[0] ? ADDR_ARM : ADDR_KICK,
                                      8 - 4 * i[0]);
        end
        check("armed_out", 1'b1, armed);
        fire_check(1, 2'b10);
    endtask : t_kick

    task automatic t_disarm();
        setup(2'b01, PER_2S);
        u_bwdt_host_model.io_read(ADDR_ARM, 4);
        u_bwdt_host_model.io_read(ADDR_DISARM, 8);
        check("armed_out", 1'b0, armed);
        quiet(60);
        u_bwdt_host_model.io_read(ADDR_KICK, 4);
        check("armed_out", 1'b0, armed);
        quiet(40);
    endtask : t_disarm

    task automatic t_disabled();
        setup(2'b00, PER_1S);
        u_bwdt_host_model.io_read(ADDR_ARM, 4);
        check("armed_out", 1'b0, armed);
        quiet(40);
        // Unlisted period code falls back to the longest period
        setup(2'b10, 4'h0);
        u_bwdt_host_model.io_read(ADDR_ARM, 4);
        fire_check(220, 2'b10);
    endtask : t_disabled

    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        rst = 1'b1;
        act = 2'b10;
        per = PER_1S;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        tick();
        check("armed_out", 1'b0, armed);
        t_periods();
        t_kick();
        t_disarm();
        t_disabled();
        final_report();
    end

endmodule : test_bwdt_top

`default_nettype wire
